// [hdl/parity_ext_defines.vh]
// Purpose: shared constants of the parity bus serial extender
// Assumes: included by bare name from the extender design file only
// Notes: slot counts are per link word, one core cycle per slot
`ifndef PARITY_EXT_DEFINES_VH
`define PARITY_EXT_DEFINES_VH

// link word framing
`define SER_SLOTS 7
`define SER_FIRST_SLOT 3'h0
`define SER_LAST_SLOT 3'h6
`define SER_SLOT_END 3'h7
`define CLK_HIGH_SLOTS 3'h4

// word layout: each byte followed by its parity bit
`define BYTE_BITS 8
`define BYTE_STRIDE 9

// recovered clock high time in core cycles
`define RX_OCLK_HIGH 3'h4

// buffering default
`define TX_FIFO_DEPTH 16
`define TX_FIFO_AW 4

`endif

// [hdl/byte_parity.v]
// Purpose: parity bit over one byte, shared by generator and checker
// Assumes: combinational use on the core clock side
// Notes: ODD selects odd sense, zero gives even sense
`timescale 1ns/1ps
module byte_parity #(
  parameter WIDTH = 8,
  parameter ODD = 0
) (
  // data in
  input wire [WIDTH-1:0] data_i,
  // parity out
  output wire parity_o
);

  assign parity_o = (^data_i) ^ (ODD != 0);

endmodule // byte_parity

// [hdl/lane_fifo.v]
// Purpose: word buffer between bus capture and serializer
// Assumes: DEPTH is a power of two, AW is its log2
// Notes: in_ready_o low exactly while full, out_valid_o high while not empty
`timescale 1ns/1ps
module lane_fifo #(
  parameter WIDTH = 21,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  localparam [AW:0] FULL_COUNT = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] count_q;

  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = (count_q != FULL_COUNT);
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_q];

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      case ({push, pop})
        2'b10: count_q <= count_q + 1'b1;
        2'b01: count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

endmodule // lane_fifo

// [hdl/parity_bus_serial_extender.v]
// Purpose: parallel bus extender with per-byte parity, lane serializer and deserializer
// Assumes: one core clock; bus clock, bus data and link pins are asynchronous to it
// Notes: LANES 3 gives the 21-bit word, LANES 4 the 28-bit word
//
// Behaviour
// - narrow build sends the word on three data lanes plus a clock lane.
// - wide build sends the word on four data lanes plus a clock lane.
// - bus clock captured on own input, bits spread over lanes, clock sent separately.
// - receiver recovers lanes and clock, unmaps, presents word with recovered clock.
// - transmit side adds one parity bit per byte, bytes pass unchanged.
// - receive side recomputes byte parity and flags each mismatching byte.
// - per-byte parity errors are ORed into one link error flag.
// - bit-to-lane assignment interleaved or lane-sequential, set by INTERLEAVE; receiver applies the exact inverse.
// - 21-bit word holds two bytes, two parity bits and three control bits.
// - 28-bit word holds three bytes, three parity bits and one control bit.
// - every parallel input bit is captured at the bus clock rising edge.
`timescale 1ns/1ps
`include "parity_ext_defines.vh"
module parity_bus_serial_extender #(
  parameter LANES = 3,
  parameter INTERLEAVE = 1,
  parameter ODD_PARITY = 0,
  parameter FIFO_DEPTH = `TX_FIFO_DEPTH,
  parameter FIFO_AW = `TX_FIFO_AW
) (
  // clock and reset
  input wire CORE_CLK_I,
  input wire RESET_I,
  // transmit parallel bus
  input wire TX_BUS_CLOCK_IN_I,
  input wire [`BYTE_BITS*(LANES-1)-1:0] TX_PARALLEL_IN_I,
  input wire [`SER_SLOTS*LANES-`BYTE_STRIDE*(LANES-1)-1:0] TX_CTRL_IN_I,
  // transmit status
  output reg TX_READY_O,
  output reg TX_OVERFLOW_O,
  // transmit link
  output reg [LANES-1:0] TX_LANE_O,
  output reg TX_CLK_LANE_O,
  // receive link
  input wire [LANES-1:0] RX_LANE_I,
  input wire RX_CLK_LANE_I,
  // receive parallel bus
  output reg [`BYTE_BITS*(LANES-1)-1:0] RX_PARALLEL_O,
  output reg [`SER_SLOTS*LANES-`BYTE_STRIDE*(LANES-1)-1:0] RX_CTRL_O,
  output reg RX_WORD_VALID_O,
  output reg RX_CLOCK_O,
  // receive checks
  output reg [LANES-2:0] RX_BYTE_ERR_O,
  output reg RX_LINK_ERR_O,
  output reg RX_FRAME_ERR_O
);

  localparam NBYTES = LANES - 1;
  localparam WORD_BITS = `SER_SLOTS * LANES;
  localparam DBITS = `BYTE_BITS * NBYTES;
  localparam NCTRL = WORD_BITS - `BYTE_STRIDE * NBYTES;
  localparam DIN = DBITS + NCTRL;

  integer l;
  integer n;

  // ---------------- transmit capture ----------------
  reg [2:0] txclk_sync_q;
  reg txclk_stable_q;
  reg [DIN-1:0] txd_s1_q;
  reg [DIN-1:0] txd_s2_q;
  reg [DIN-1:0] txd_s3_q;
  reg [DIN-1:0] txd_s4_q;

  // edge counts only once the second and third stages agree high
  wire tx_rise = txclk_sync_q[1] & txclk_sync_q[2] & ~txclk_stable_q;

  always @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      txclk_sync_q <= 3'h0;
      txclk_stable_q <= 1'b0;
      txd_s1_q <= {DIN{1'b0}};
      txd_s2_q <= {DIN{1'b0}};
      txd_s3_q <= {DIN{1'b0}};
      txd_s4_q <= {DIN{1'b0}};
    end else begin
      txclk_sync_q <= {txclk_sync_q[1:0], TX_BUS_CLOCK_IN_I};
      if (txclk_sync_q[1] == txclk_sync_q[2]) begin
        txclk_stable_q <= txclk_sync_q[2];
      end
      txd_s1_q <= {TX_CTRL_IN_I, TX_PARALLEL_IN_I};
      txd_s2_q <= txd_s1_q;
      txd_s3_q <= txd_s2_q;
      // one stage deeper than the clock so the pre-edge value is taken
      txd_s4_q <= txd_s3_q;
    end
  end

  // ---------------- parity generation and word build ----------------
  wire [WORD_BITS-1:0] tx_word;
  wire [WORD_BITS-1:0] rx_word;
  wire [NBYTES-1:0] rx_calc_par;
  wire [NBYTES-1:0] rx_byte_err;

  genvar b;
  generate
    for (b = 0; b < NBYTES; b = b + 1) begin : g_byte
      wire tx_par;
      byte_parity #(
        .WIDTH(`BYTE_BITS),
        .ODD(ODD_PARITY)
      ) u_tx_par (
        .data_i(txd_s4_q[b*`BYTE_BITS +: `BYTE_BITS]),
        .parity_o(tx_par)
      );
      // byte passes unchanged, parity bit placed above it
      assign tx_word[b*`BYTE_STRIDE +: `BYTE_BITS] = txd_s4_q[b*`BYTE_BITS +: `BYTE_BITS];
      assign tx_word[b*`BYTE_STRIDE + `BYTE_BITS] = tx_par;

      byte_parity #(
        .WIDTH(`BYTE_BITS),
        .ODD(ODD_PARITY)
      ) u_rx_par (
        .data_i(rx_word[b*`BYTE_STRIDE +: `BYTE_BITS]),
        .parity_o(rx_calc_par[b])
      );
      assign rx_byte_err[b] = rx_calc_par[b] ^ rx_word[b*`BYTE_STRIDE + `BYTE_BITS];
    end
  endgenerate

  // control bits fill the top of the word: 3 in the narrow build, 1 in the wide
  assign tx_word[WORD_BITS-1 -: NCTRL] = txd_s4_q[DIN-1 -: NCTRL];

  // ---------------- transmit buffer ----------------
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [WORD_BITS-1:0] fifo_out_data;

  lane_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(CORE_CLK_I),
    .reset_i(RESET_I),
    .in_valid_i(tx_rise),
    .in_ready_o(fifo_in_ready),
    .in_data_i(tx_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  always @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      TX_READY_O <= 1'b0;
      TX_OVERFLOW_O <= 1'b0;
    end else begin
      TX_READY_O <= fifo_in_ready;
      // a bus word arriving while the buffer is full is dropped
      TX_OVERFLOW_O <= tx_rise & ~fifo_in_ready;
    end
  end

  // ---------------- lane mapping and its inverse ----------------
  wire [WORD_BITS-1:0] fifo_map;
  reg [WORD_BITS-1:0] rx_map_q;

  genvar w;
  generate
    for (w = 0; w < WORD_BITS; w = w + 1) begin : g_map
      localparam integer LN = (INTERLEAVE != 0) ? (w % LANES) : (w / `SER_SLOTS);
      localparam integer SL = (INTERLEAVE != 0) ? (w / LANES) : (w % `SER_SLOTS);
      // map position is lane*7+slot; the same pair is used both ways
      assign fifo_map[LN*`SER_SLOTS + SL] = fifo_out_data[w];
      assign rx_word[w] = rx_map_q[LN*`SER_SLOTS + SL];
    end
  endgenerate

  // ---------------- serializer ----------------
  reg [WORD_BITS-1:0] ser_map_q;
  reg ser_busy_q;
  reg [2:0] ser_slot_q;
  wire [LANES-1:0] ser_first_bits;
  wire [LANES-1:0] ser_cur_bits;

  genvar k;
  generate
    for (k = 0; k < LANES; k = k + 1) begin : g_lane
      assign ser_first_bits[k] = fifo_map[k*`SER_SLOTS];
      assign ser_cur_bits[k] = ser_map_q[k*`SER_SLOTS + ser_slot_q];
    end
  endgenerate

  wire ser_take = ~ser_busy_q | (ser_slot_q == `SER_SLOT_END);
  assign fifo_out_ready = ser_take;

  always @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      ser_map_q <= {WORD_BITS{1'b0}};
      ser_busy_q <= 1'b0;
      ser_slot_q <= `SER_FIRST_SLOT;
      TX_LANE_O <= {LANES{1'b0}};
      TX_CLK_LANE_O <= 1'b0;
    end else if (ser_take) begin
      if (fifo_out_valid) begin
        ser_map_q <= fifo_map;
        ser_busy_q <= 1'b1;
        ser_slot_q <= `SER_FIRST_SLOT + 3'h1;
        TX_LANE_O <= ser_first_bits;
        TX_CLK_LANE_O <= 1'b1;
      end else begin
        // idle link: lanes and clock lane held low
        ser_busy_q <= 1'b0;
        ser_slot_q <= `SER_FIRST_SLOT;
        TX_LANE_O <= {LANES{1'b0}};
        TX_CLK_LANE_O <= 1'b0;
      end
    end else begin
      ser_slot_q <= ser_slot_q + 3'h1;
      TX_LANE_O <= ser_cur_bits;
      // clock lane high for slots 0..3, low for 4..6
      TX_CLK_LANE_O <= (ser_slot_q < `CLK_HIGH_SLOTS);
    end
  end

  // ---------------- receive synchronisers ----------------
  reg [2:0] rxclk_sync_q;
  reg rxclk_stable_q;
  reg [LANES-1:0] rxl_s1_q;
  reg [LANES-1:0] rxl_s2_q;
  reg [LANES-1:0] rxl_s3_q;

  wire rx_rise = rxclk_sync_q[1] & rxclk_sync_q[2] & ~rxclk_stable_q;

  always @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      rxclk_sync_q <= 3'h0;
      rxclk_stable_q <= 1'b0;
      rxl_s1_q <= {LANES{1'b0}};
      rxl_s2_q <= {LANES{1'b0}};
      rxl_s3_q <= {LANES{1'b0}};
    end else begin
      rxclk_sync_q <= {rxclk_sync_q[1:0], RX_CLK_LANE_I};
      if (rxclk_sync_q[1] == rxclk_sync_q[2]) begin
        rxclk_stable_q <= rxclk_sync_q[2];
      end
      rxl_s1_q <= RX_LANE_I;
      rxl_s2_q <= rxl_s1_q;
      rxl_s3_q <= rxl_s2_q;
    end
  end

  // ---------------- deserializer ----------------
  reg rx_active_q;
  reg [2:0] rx_slot_q;
  reg rx_done_q;
  reg rx_cut_q;

  always @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      rx_map_q <= {WORD_BITS{1'b0}};
      rx_active_q <= 1'b0;
      rx_slot_q <= `SER_FIRST_SLOT;
      rx_done_q <= 1'b0;
      rx_cut_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      rx_cut_q <= 1'b0;
      if (rx_rise) begin
        // clock lane rise marks slot 0; a rise mid-word restarts the word
        rx_cut_q <= rx_active_q;
        for (l = 0; l < LANES; l = l + 1) begin
          rx_map_q[l*`SER_SLOTS] <= rxl_s3_q[l];
        end
        rx_slot_q <= `SER_FIRST_SLOT + 3'h1;
        rx_active_q <= 1'b1;
      end else if (rx_active_q) begin
        for (l = 0; l < LANES; l = l + 1) begin
          rx_map_q[l*`SER_SLOTS + rx_slot_q] <= rxl_s3_q[l];
        end
        rx_slot_q <= rx_slot_q + 3'h1;
        if (rx_slot_q == `SER_LAST_SLOT) begin
          rx_active_q <= 1'b0;
          rx_done_q <= 1'b1;
        end
      end
    end
  end

  // ---------------- receive presentation ----------------
  reg [2:0] rx_oclk_cnt_q;

  always @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      RX_PARALLEL_O <= {DBITS{1'b0}};
      RX_CTRL_O <= {NCTRL{1'b0}};
      RX_BYTE_ERR_O <= {NBYTES{1'b0}};
      RX_LINK_ERR_O <= 1'b0;
      RX_WORD_VALID_O <= 1'b0;
      RX_CLOCK_O <= 1'b0;
      RX_FRAME_ERR_O <= 1'b0;
      rx_oclk_cnt_q <= 3'h0;
    end else begin
      RX_WORD_VALID_O <= rx_done_q;
      RX_FRAME_ERR_O <= rx_cut_q;
      if (rx_done_q) begin
        for (n = 0; n < NBYTES; n = n + 1) begin
          RX_PARALLEL_O[n*`BYTE_BITS +: `BYTE_BITS] <= rx_word[n*`BYTE_STRIDE +: `BYTE_BITS];
        end
        RX_CTRL_O <= rx_word[WORD_BITS-1 -: NCTRL];
        RX_BYTE_ERR_O <= rx_byte_err;
        RX_LINK_ERR_O <= |rx_byte_err;
        // data changes with the recovered clock low; it rises one cycle later
        RX_CLOCK_O <= 1'b0;
        rx_oclk_cnt_q <= `RX_OCLK_HIGH;
      end else if (rx_oclk_cnt_q != 3'h0) begin
        RX_CLOCK_O <= 1'b1;
        rx_oclk_cnt_q <= rx_oclk_cnt_q - 3'h1;
      end else begin
        RX_CLOCK_O <= 1'b0;
      end
    end
  end

endmodule // parity_bus_serial_extender

// [tb/ext_chk_assertions.sv]
// Purpose: assertions on the extender pins
// Assumes: one core clock domain, narrow or wide build
// Notes: quiet counters saturate at 15
`timescale 1ns/1ps
module ext_chk #(parameter LANES = 3) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  // transmit side
  input wire logic TX_BUS_CLOCK_IN_I,
  input wire logic TX_OVERFLOW_O,
  input wire logic [LANES-1:0] TX_LANE_O,
  input wire logic TX_CLK_LANE_O,
  // receive side
  input wire logic RX_CLK_LANE_I,
  input wire logic [8*(LANES-1)-1:0] RX_PARALLEL_O,
  input wire logic RX_WORD_VALID_O,
  input wire logic RX_CLOCK_O,
  input wire logic [LANES-2:0] RX_BYTE_ERR_O,
  input wire logic RX_LINK_ERR_O,
  input wire logic RX_FRAME_ERR_O
);
  logic [3:0] tq_q;
  logic [3:0] rq_q;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  // cycles since each clock lane was last high
  always @(posedge CORE_CLK_I) begin
    tq_q <= (RESET_I || TX_CLK_LANE_O) ? 4'h0 : tq_q + {3'h0, tq_q != 4'hF};
    rq_q <= (RESET_I || RX_CLK_LANE_I) ? 4'h0 : rq_q + {3'h0, rq_q != 4'hF};
  end
  property p_or; RX_LINK_ERR_O == |RX_BYTE_ERR_O; endproperty
  a_or: assert property (p_or) else $error("link flag");
  property p_clk; $rose(TX_CLK_LANE_O) |-> TX_CLK_LANE_O [*4] ##1 (!TX_CLK_LANE_O) [*3]; endproperty
  a_clk: assert property (p_clk) else $error("clock lane shape");
  property p_idle; (!TX_CLK_LANE_O) [*4] |-> TX_LANE_O == '0; endproperty
  a_idle: assert property (p_idle) else $error("idle lanes");
  property p_txl; $rose(TX_BUS_CLOCK_IN_I) && tq_q > 4'h3 |-> ##[2:7] TX_CLK_LANE_O; endproperty
  a_txl: assert property (p_txl) else $error("capture late");
  property p_rxc; RX_WORD_VALID_O |-> !RX_CLOCK_O ##1 RX_CLOCK_O [*4] ##1 !RX_CLOCK_O; endproperty
  a_rxc: assert property (p_rxc) else $error("recovered clock");
  property p_hold; !RX_WORD_VALID_O |-> $stable(RX_PARALLEL_O) && $stable(RX_BYTE_ERR_O); endproperty
  a_hold: assert property (p_hold) else $error("word not held");
  property p_errv; $changed(RX_LINK_ERR_O) |-> RX_WORD_VALID_O; endproperty
  a_errv: assert property (p_errv) else $error("error off word");
  property p_rxl; $rose(RX_CLK_LANE_I) && rq_q > 4'h7 |-> ##[1:14] (RX_WORD_VALID_O || RX_FRAME_ERR_O); endproperty
  a_rxl: assert property (p_rxl) else $error("word lost");
  property p_ovf; TX_OVERFLOW_O |=> !TX_OVERFLOW_O; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow pulse");
endmodule // ext_chk

bind parity_bus_serial_extender ext_chk #(.LANES(LANES)) rules_chk (
  .CORE_CLK_I(CORE_CLK_I),
  .RESET_I(RESET_I),
  .TX_BUS_CLOCK_IN_I(TX_BUS_CLOCK_IN_I),
  .TX_OVERFLOW_O(TX_OVERFLOW_O),
  .TX_LANE_O(TX_LANE_O),
  .TX_CLK_LANE_O(TX_CLK_LANE_O),
  .RX_CLK_LANE_I(RX_CLK_LANE_I),
  .RX_PARALLEL_O(RX_PARALLEL_O),
  .RX_WORD_VALID_O(RX_WORD_VALID_O),
  .RX_CLOCK_O(RX_CLOCK_O),
  .RX_BYTE_ERR_O(RX_BYTE_ERR_O),
  .RX_LINK_ERR_O(RX_LINK_ERR_O),
  .RX_FRAME_ERR_O(RX_FRAME_ERR_O)
);

// [tb/far_link.sv]
// Purpose: far end of the cable, decodes and sends link words
// Assumes: interleaved mapping, one slot per core cycle
// Notes: send with cut 6 restarts the word mid-frame; a one-slot low clock is filtered
`timescale 1ns/1ps
module far_link #(parameter LANES = 3) (
  // core clock
  input wire logic clk_i,
  // link from the block
  input wire logic [LANES-1:0] lane_i,
  input wire logic clk_lane_i,
  // link towards the block
  output logic [LANES-1:0] lane_o,
  output logic clk_lane_o,
  // decoded words
  output logic [7*LANES-1:0] word_o,
  output int count_o
);
  int slot = 7;
  logic prev = 1'b0;
  logic [7*LANES-1:0] acc;
  initial begin
    lane_o = '0;
    clk_lane_o = 1'b0;
    count_o = 0;
  end
  function automatic logic [LANES-1:0] pick(input logic [7*LANES-1:0] w, input int s);
    for (int l = 0; l < LANES; l++) pick[l] = w[s*LANES+l];
  endfunction
  always @(posedge clk_i) begin
    if (clk_lane_i === 1'b1 && !prev) slot = 0;
    if (slot < 7) begin
      for (int l = 0; l < LANES; l++) acc[slot*LANES+l] = lane_i[l];
      slot++;
      if (slot == 7) begin
        word_o <= acc;
        count_o <= count_o + 1;
      end
    end
    prev = (clk_lane_i === 1'b1);
  end
  task automatic send(input logic [7*LANES-1:0] w, input int cut);
    int s;
    for (int i = 0; i < 7 + cut; i++) begin
      @(posedge clk_i);
      s = (cut > 0 && i >= cut) ? i - cut : i;
      clk_lane_o <= (s < 4);
      lane_o <= pick(w, s);
    end
    @(posedge clk_i);
    clk_lane_o <= 1'b0;
    // released lanes show the inverse of the last slot
    lane_o <= ~lane_o;
  endtask
endmodule // far_link

// [tb/tb_top.sv]
// Purpose: self-checking bench for the extender
// Assumes: narrow build, interleaved lanes, even parity
// Notes: loop feeds the transmit link back to the receiver
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, bclk = 0, run = 0, loop = 1;
  logic [15:0] pin = '0;
  logic [2:0] ctl = '0;
  logic [2:0] txl, fl, rctl;
  logic txc, fc, rdy, ovf, wv, rck, lerr, ferr;
  logic [15:0] rpar;
  logic [1:0] berr;
  logic [20:0] fw;
  int fcnt, errors = 0, comparisons = 0, cyc = 0;
  wire [2:0] rxl = loop ? txl : fl;
  wire rxc = loop ? txc : fc;
  parity_bus_serial_extender dut (
    .CORE_CLK_I(clk),
    .RESET_I(rst),
    .TX_BUS_CLOCK_IN_I(bclk),
    .TX_PARALLEL_IN_I(pin),
    .TX_CTRL_IN_I(ctl),
    .TX_READY_O(rdy),
    .TX_OVERFLOW_O(ovf),
    .TX_LANE_O(txl),
    .TX_CLK_LANE_O(txc),
    .RX_LANE_I(rxl),
    .RX_CLK_LANE_I(rxc),
    .RX_PARALLEL_O(rpar),
    .RX_CTRL_O(rctl),
    .RX_WORD_VALID_O(wv),
    .RX_CLOCK_O(rck),
    .RX_BYTE_ERR_O(berr),
    .RX_LINK_ERR_O(lerr),
    .RX_FRAME_ERR_O(ferr)
  );
  far_link far (
    .clk_i(clk),
    .lane_i(txl),
    .clk_lane_i(txc),
    .lane_o(fl),
    .clk_lane_o(fc),
    .word_o(fw),
    .count_o(fcnt)
  );
  initial forever #2 clk = ~clk;
  // bus clock of 125 ns, free of the core phase
  initial begin
    #3.1;
    forever begin
      #62.5;
      if (run) bclk = ~bclk;
    end
  end
  function automatic logic [20:0] mk(input logic [15:0] d, input logic [2:0] c);
    mk = {c, ^d[15:8], d[15:8], ^d[7:0], d[7:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_rx();
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wv !== 1'b1 && n < 60);
    chk(n < 60, 1);
  endtask
  task automatic t_loop();
    logic [15:0] d [4] = '{16'h0000, 16'hFFFF, 16'h01A5, 16'h807E};
    run = 1;
    for (int i = 0; i < 8; i++) begin
      @(negedge bclk);
      @(posedge clk);
      pin <= d[i % 4];
      ctl <= i[2:0];
      @(posedge bclk);
      wait_rx();
      chk(fw, mk(d[i % 4], i[2:0]));
      chk({rctl, berr, lerr, rck, rpar}, {i[2:0], 4'h0, d[i % 4]});
    end
    @(negedge bclk);
    run = 0;
  endtask
  task automatic t_perr();
    logic [20:0] m [5] = '{21'h000001, 21'h020000, 21'h000201, 21'h000003, 21'h040000};
    logic [1:0] e [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    logic [20:0] w;
    loop = 0;
    for (int i = 0; i < 5; i++) begin
      w = mk(16'h3C5A, 3'h5) ^ m[i];
      fork
        far.send(w, 0);
        wait_rx();
      join
      chk({berr, lerr}, {e[i], |e[i]});
      chk(rpar, {w[16:9], w[7:0]});
    end
  endtask
  task automatic t_frame();
    int nf = 0, nv = 0;
    fork
      far.send(mk(16'hBEEF, 3'h2), 6);
      repeat (40) begin
        @(negedge clk);
        nf += (ferr === 1'b1);
        if (wv === 1'b1) begin
          nv++;
          chk({rctl, rpar}, {3'h2, 16'hBEEF});
        end
      end
    join
    chk(nf, 1);
    chk(nv, 1);
  endtask
  task automatic t_ovf();
    int nov = 0, nlow = 0, c0;
    c0 = fcnt;
    loop = 1;
    // bus clock at its 40 MHz ceiling outruns the 7-slot serializer
    fork
      repeat (300) begin
        #12.5 bclk = 1'b1;
        #12.5 bclk = 1'b0;
      end
      repeat (1900) begin
        @(negedge clk);
        nov += (ovf === 1'b1);
        nlow += (rdy === 1'b0);
      end
    join
    repeat (250) @(posedge clk);
    @(negedge clk);
    chk({nov > 0, nlow > 0, rdy}, 3'h7);
    chk(fcnt - c0, 300 - nov);
  endtask
  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("CHECK FAILED %0t: timeout", $time);
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({rdy, txl, txc, wv, lerr}, 7'h40);
    t_loop();
    t_perr();
    t_frame();
    t_ovf();
    end_of_test();
  end
endmodule // tb_top
